/* hw/crp_pkg.sv */
/*
  crp_pkg: constants, carrier types and shared helpers for the CAN result publisher.
  Assumes a 200 MHz core clock and a CAN controller that takes one whole frame at a time.
*/
package crp_pkg;

  localparam int N_RES = 16;
  localparam int N_MSG = 8;
  localparam int MSG_W = 3;
  localparam int OFF_W = 6;
  localparam int LEN_W = 7;
  localparam int ID_W = 11;
  localparam int DLC_W = 4;
  localparam int FLOAT_BYTES = 4;
  localparam int CLASSIC_BYTES = 8;
  localparam int FD_BYTES = 64;
  localparam int DATA_W = FD_BYTES * 8;

  // timing
  localparam int CLK_HZ = 200_000_000;
  localparam int START_MS = 25;
  localparam int CANCEL_MS = 100;
  localparam int START_CYC = START_MS * (CLK_HZ / 1000);
  localparam int CANCEL_CYC = CANCEL_MS * (CLK_HZ / 1000);

  // bus load estimate: fixed frame bits besides the data field
  localparam int OVH_CLASSIC_BITS = 47;
  localparam int OVH_FD_BITS = 67;
  localparam int PCT_SCALE = 100;
  localparam int PCT_MAX = 255;
  // overload: stretch step is (period >> STRETCH_UP) + 1, relief period >> STRETCH_DN
  localparam int STRETCH_UP = 3;
  localparam int STRETCH_DN = 5;

  typedef struct packed {
    logic en;
    logic [MSG_W-1:0] msg;
    logic [OFF_W-1:0] byte_off;
  } crp_res_cfg_t;

  typedef struct packed {
    logic en;
    logic [ID_W-1:0] id;
    logic [LEN_W-1:0] len;
  } crp_msg_cfg_t;

  typedef struct packed {
    logic [ID_W-1:0] id;
    logic ide;
    logic fd;
    logic [DLC_W-1:0] dlc;
    logic [DATA_W-1:0] data;
  } crp_frame_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SCAN,
    ST_SEND
  } crp_state_t;

  // legal data length for the bus mode (classic clamps, fd rounds up)
  function automatic logic [LEN_W-1:0] crp_len(input logic fd, input logic [LEN_W-1:0] len);
    logic [LEN_W-1:0] r;
    r = len;
    if (!fd)
    begin
      if (len > LEN_W'(CLASSIC_BYTES))
        r = LEN_W'(CLASSIC_BYTES);
    end
    else if (len <= 7'h08)
      r = len;
    else if (len <= 7'h0C)
      r = 7'h0C;
    else if (len <= 7'h10)
      r = 7'h10;
    else if (len <= 7'h14)
      r = 7'h14;
    else if (len <= 7'h18)
      r = 7'h18;
    else if (len <= 7'h20)
      r = 7'h20;
    else if (len <= 7'h30)
      r = 7'h30;
    else
      r = 7'h40;
    return r;
  endfunction

  function automatic logic [DLC_W-1:0] crp_dlc(input logic [LEN_W-1:0] len);
    logic [DLC_W-1:0] d;
    if (len <= 7'h08)
      d = len[DLC_W-1:0];
    else if (len <= 7'h0C)
      d = 4'h9;
    else if (len <= 7'h10)
      d = 4'hA;
    else if (len <= 7'h14)
      d = 4'hB;
    else if (len <= 7'h18)
      d = 4'hC;
    else if (len <= 7'h20)
      d = 4'hD;
    else if (len <= 7'h30)
      d = 4'hE;
    else
      d = 4'hF;
    return d;
  endfunction

endpackage

/* hw/crp_frame_packer.sv */
/*
  crp_frame_packer: builds one frame of the packet from the latched snapshot.
  Assumes snapshot and configuration are held stable by the caller; purely combinational.
*/
`timescale 1ns/1ps
module crp_frame_packer (
  input wire logic fd_mode, // 1: flexible data rate frames
  input wire logic [crp_pkg::MSG_W-1:0] msg_sel, // message being built
  input crp_pkg::crp_msg_cfg_t msg_cfg, // config of that message
  input crp_pkg::crp_res_cfg_t [crp_pkg::N_RES-1:0] res_cfg, // placement per result
  input wire logic [crp_pkg::N_RES-1:0][31:0] results, // single-precision words
  output crp_pkg::crp_frame_t frame // assembled frame
);

  always_comb
  begin
    logic [crp_pkg::LEN_W-1:0] len;
    int off;
    len = crp_pkg::crp_len(fd_mode, msg_cfg.len);
    off = 0;
    frame = '0;
    frame.id = msg_cfg.id;
    frame.ide = 1'b0;
    frame.fd = fd_mode;
    frame.dlc = crp_pkg::crp_dlc(len);
    for (int r = 0; r < crp_pkg::N_RES; r++)
    begin
      off = int'(res_cfg[r].byte_off);
      // results assigned to this message land in this frame if they fit its length, msb first at the range start
      if (res_cfg[r].en && res_cfg[r].msg == msg_sel &&
          off + crp_pkg::FLOAT_BYTES <= int'(len))
      begin
        for (int b = 0; b < crp_pkg::FLOAT_BYTES; b++)
          frame.data[(off + b) * 8 +: 8] = results[r][31 - 8 * b -: 8];
      end
    end
  end

endmodule

/* hw/crp_result_publisher.sv */
/*
  crp_result_publisher: periodic publisher of computed results as CAN frames.
  Assumes a CAN controller on the same clock that takes frame while frame_valid is high,
  pulses tx_done when the frame went out and tx_lost when arbitration was lost; all
  configuration inputs come from logic on this clock and are static while publishing.
*/
`timescale 1ns/1ps
// What this block does
// - Only base frames with 11-bit identifiers are sent, never extended ones.
// - Classic or flexible-data-rate bus mode, chosen by a configuration input.
// - A 4-bit length code; data field 0..8 bytes classic, 0..64 fd.
// - Each result goes out as a 32-bit float in four consecutive bytes.
// - Classic frames hold one or two results, fd frames up to sixteen.
// - Each result has an identifier; results sharing it share a message.
// - A per-result byte offset places its four bytes in the data field, if they fit the message length.
// - Every configured message of a cycle goes out together as one packet.
// - Every message is attempted; a lost arbitration retries the same message.
// - Bus load percentage is reported from mode, rate, messages and lengths.
// - Results are published periodically at the configured rate, unrequested.
// - Fd frames follow the ISO CAN FD format.
// - One packet holds one snapshot; snapshots are spaced by the period.
// - Publishing starts within 25 ms after the snapshot is calculated.
// - After 100 ms waiting for the bus, the rest of the packet is cancelled.
// - Under lasting overload the packet rate drops to what the bus sustains.
module crp_result_publisher #(
  parameter int CANCEL_CYC = crp_pkg::CANCEL_CYC // publish timeout in cycles
) (
  input wire logic clk, // core clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic fd_mode, // 1: flexible data rate bus mode
  input wire logic [31:0] period_cyc, // update period in clock cycles
  input wire logic [15:0] bit_time_cyc, // nominal bit time in clock cycles
  input crp_pkg::crp_msg_cfg_t [crp_pkg::N_MSG-1:0] msg_cfg, // message table
  input crp_pkg::crp_res_cfg_t [crp_pkg::N_RES-1:0] res_cfg, // result placement
  input wire logic calc_done, // pulse: results of the last sample are ready
  input wire logic [crp_pkg::N_RES-1:0][31:0] calc_results, // results with calc_done
  input wire logic tx_done, // pulse: current frame sent
  input wire logic tx_lost, // pulse: arbitration lost, frame not sent
  output logic sample_strobe, // pulse: take a snapshot now
  output logic [31:0] sample_time, // timestamp of the snapshot, in cycles
  output crp_pkg::crp_frame_t frame, // frame offered to the controller
  output logic frame_valid, // frame is offered
  output logic pkt_busy, // a packet is being published
  output logic pkt_cancel, // pulse: packet cancelled by timeout
  output logic pkt_skip, // pulse: snapshot dropped, bus still busy
  output logic [31:0] eff_period, // period in use after overload stretch
  output logic [7:0] bus_load_pct // estimated bus load in percent
);

  crp_pkg::crp_state_t state;
  logic [31:0] per_cnt;
  logic [31:0] stretch;
  logic [31:0] pub_timer;
  logic [crp_pkg::MSG_W-1:0] msg_idx;
  logic [crp_pkg::N_RES-1:0][31:0] snap;
  crp_pkg::crp_frame_t next_frame;
  logic [47:0] next_load;
  logic any_en;
  logic last_msg;
  logic timeout;
  logic pkt_end;

  assign last_msg = (msg_idx == crp_pkg::MSG_W'(crp_pkg::N_MSG - 1));
  assign timeout = (pub_timer >= 32'(CANCEL_CYC));
  // packet closed cleanly: last slot sent, or last slot disabled and skipped
  assign pkt_end = last_msg && ((state == crp_pkg::ST_SEND && tx_done) ||
                   (state == crp_pkg::ST_SCAN && !timeout && !msg_cfg[msg_idx].en));

  always_comb
  begin
    any_en = 1'b0;
    for (int m = 0; m < crp_pkg::N_MSG; m++)
      any_en = any_en | msg_cfg[m].en;
  end

  crp_frame_packer u_packer (
    .fd_mode(fd_mode),
    .msg_sel(msg_idx),
    .msg_cfg(msg_cfg[msg_idx]),
    .res_cfg(res_cfg),
    .results(snap),
    .frame(next_frame)
  );

  // period timer and timestamps
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      per_cnt <= 32'h0000_0000;
      sample_strobe <= 1'b0;
      sample_time <= 32'h0000_0000;
      eff_period <= 32'h0000_0000;
    end
    else
    begin
      eff_period <= period_cyc + stretch;
      sample_strobe <= 1'b0;
      if (per_cnt + 32'h1 >= eff_period)
      begin
        per_cnt <= 32'h0000_0000;
        sample_strobe <= 1'b1;
        sample_time <= sample_time + eff_period;
      end
      else
        per_cnt <= per_cnt + 32'h1;
    end
  end

  // overload: stretch on a dropped or cancelled packet, relax on a clean one
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      stretch <= 32'h0000_0000;
    else if (pkt_skip || pkt_cancel)
      stretch <= stretch + (period_cyc >> crp_pkg::STRETCH_UP) + 32'h1;
    else if (pkt_end)
    begin
      if (stretch > (period_cyc >> crp_pkg::STRETCH_DN))
        stretch <= stretch - (period_cyc >> crp_pkg::STRETCH_DN);
      else
        stretch <= 32'h0000_0000;
    end
  end

  // packet sequencer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= crp_pkg::ST_IDLE;
      msg_idx <= '0;
      snap <= '0;
      frame <= '0;
      frame_valid <= 1'b0;
      pub_timer <= 32'h0000_0000;
      pkt_cancel <= 1'b0;
      pkt_skip <= 1'b0;
    end
    else
    begin
      pkt_cancel <= 1'b0;
      pkt_skip <= 1'b0;
      if (calc_done && state != crp_pkg::ST_IDLE)
        pkt_skip <= 1'b1;
      if (state != crp_pkg::ST_IDLE)
        pub_timer <= pub_timer + 32'h1;
      case (state)
        crp_pkg::ST_IDLE:
        begin
          pub_timer <= 32'h0000_0000;
          if (calc_done && any_en)
          begin
            snap <= calc_results;
            msg_idx <= '0;
            state <= crp_pkg::ST_SCAN;
          end
        end
        crp_pkg::ST_SCAN:
        begin
          if (timeout)
          begin
            pkt_cancel <= 1'b1;
            state <= crp_pkg::ST_IDLE;
          end
          else if (msg_cfg[msg_idx].en)
          begin
            frame <= next_frame;
            frame_valid <= 1'b1;
            state <= crp_pkg::ST_SEND;
          end
          else if (last_msg)
            state <= crp_pkg::ST_IDLE;
          else
            msg_idx <= msg_idx + crp_pkg::MSG_W'(1);
        end
        crp_pkg::ST_SEND:
        begin
          if (tx_done)
          begin
            frame_valid <= 1'b0;
            msg_idx <= msg_idx + crp_pkg::MSG_W'(1);
            state <= last_msg ? crp_pkg::ST_IDLE : crp_pkg::ST_SCAN;
          end
          else if (timeout)
          begin
            frame_valid <= 1'b0;
            pkt_cancel <= 1'b1;
            state <= crp_pkg::ST_IDLE;
          end
          // a lost arbitration keeps the same frame offered for retry
        end
        default:
          state <= crp_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pkt_busy <= 1'b0;
    else
      pkt_busy <= (state != crp_pkg::ST_IDLE);
  end

  // bus load estimate: packet bits * bit time * 100 / period
  always_comb
  begin
    logic [31:0] bits;
    bits = 32'h0000_0000;
    for (int m = 0; m < crp_pkg::N_MSG; m++)
      if (msg_cfg[m].en)
        bits = bits + 32'(fd_mode ? crp_pkg::OVH_FD_BITS : crp_pkg::OVH_CLASSIC_BITS)
               + 32'(crp_pkg::crp_len(fd_mode, msg_cfg[m].len)) * 32'h8;
    next_load = (48'(bits) * 48'(bit_time_cyc) * 48'(crp_pkg::PCT_SCALE))
                / 48'((eff_period == 32'h0) ? 32'h1 : eff_period);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      bus_load_pct <= 8'h00;
    else if (next_load > 48'(crp_pkg::PCT_MAX))
      bus_load_pct <= 8'hFF;
    else
      bus_load_pct <= next_load[7:0];
  end

  property p_base_only;
    @(posedge clk) disable iff (!rst_n)
      frame_valid |-> !frame.ide && frame.id == msg_cfg[msg_idx].id;
  endproperty
  a_base_only: assert property (p_base_only) else $error("extended or wrong id frame");

  property p_classic_len;
    @(posedge clk) disable iff (!rst_n)
      frame_valid && !frame.fd |-> frame.dlc <= 4'h8 && frame.data[crp_pkg::DATA_W-1:64] == '0;
  endproperty
  a_classic_len: assert property (p_classic_len) else $error("classic frame too long");

  property p_mode;
    @(posedge clk) disable iff (!rst_n) frame_valid |-> frame.fd == fd_mode;
  endproperty
  a_mode: assert property (p_mode) else $error("frame mode differs from bus mode");

  property p_retry;
    @(posedge clk) disable iff (!rst_n)
      frame_valid && tx_lost && !tx_done && !timeout |=> frame_valid && $stable(frame);
  endproperty
  a_retry: assert property (p_retry) else $error("lost frame not retried");

  property p_start;
    @(posedge clk) disable iff (!rst_n)
      state == crp_pkg::ST_IDLE && calc_done && msg_cfg[0].en |-> ##2 frame_valid;
  endproperty
  a_start: assert property (p_start) else $error("publishing did not start");

  property p_cancel;
    @(posedge clk) disable iff (!rst_n)
      state == crp_pkg::ST_SEND && timeout && !tx_done |=> pkt_cancel && !frame_valid;
  endproperty
  a_cancel: assert property (p_cancel) else $error("timeout did not cancel");

  property p_spacing;
    @(posedge clk) disable iff (!rst_n)
      sample_strobe |-> sample_time == $past(sample_time) + $past(eff_period);
  endproperty
  a_spacing: assert property (p_spacing) else $error("timestamp spacing wrong");

  property p_overload;
    @(posedge clk) disable iff (!rst_n)
      calc_done && state != crp_pkg::ST_IDLE |=> pkt_skip ##1 stretch > $past(stretch, 2);
  endproperty
  a_overload: assert property (p_overload) else $error("overload did not stretch");

endmodule

/* verification/crp_ctrl_model.sv */
/*
  crp_ctrl_model: behavioural CAN controller that takes frames from the publisher.
  Assumes the publisher's clock; the bench sets answer delay, losses per frame and stall.
*/
`timescale 1ns/1ps
module crp_ctrl_model (
  input wire logic clk, // core clock
  input wire logic rst_n, // reset, active low
  input crp_pkg::crp_frame_t frame, // offered frame
  input wire logic frame_valid, // frame offered
  input int delay, // cycles before an answer
  input int lose_n, // arbitration losses per frame
  input wire logic stall, // bus never becomes free
  output logic tx_done, // pulse: frame sent
  output logic tx_lost // pulse: arbitration lost
);
  crp_pkg::crp_frame_t got[$];
  int cnt;
  int lost;
  int n_lost;
  logic sent;

  // lose_n tx_lost answers, then one tx_done per offer; waits for the offer to drop before taking the next
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 0;
      lost <= 0;
      n_lost <= 0;
      sent <= 1'b0;
      tx_done <= 1'b0;
      tx_lost <= 1'b0;
    end
    else
    begin
      tx_done <= 1'b0;
      tx_lost <= 1'b0;
      if (!frame_valid)
      begin
        sent <= 1'b0;
        cnt <= 0;
        lost <= 0;
      end
      else if (!sent && !stall && !tx_done && !tx_lost)
      begin
        if (cnt < delay)
          cnt <= cnt + 1;
        else
        begin
          cnt <= 0;
          if (lost < lose_n)
          begin
            tx_lost <= 1'b1;
            lost <= lost + 1;
            n_lost <= n_lost + 1;
          end
          else
          begin
            tx_done <= 1'b1;
            sent <= 1'b1;
            got.push_back(frame);
          end
        end
      end
    end
  end
endmodule

/* verification/test_can_result_publisher.sv */
/*
  test_can_result_publisher: directed scenarios for the result publisher.
  Assumes crp_ctrl_model as the controller; short cancel count for simulation.
*/
`timescale 1ns/1ps
module test_can_result_publisher;
  localparam int CANCEL = 200;
  localparam int P = 2000;
  localparam int FW = $bits(crp_pkg::crp_frame_t);
  logic clk;
  logic rst_n;
  logic fd_mode;
  logic [31:0] period_cyc;
  logic [15:0] bit_time_cyc;
  crp_pkg::crp_msg_cfg_t [crp_pkg::N_MSG-1:0] msg_cfg;
  crp_pkg::crp_res_cfg_t [crp_pkg::N_RES-1:0] res_cfg;
  logic calc_done;
  logic [crp_pkg::N_RES-1:0][31:0] calc_results;
  logic tx_done;
  logic tx_lost;
  logic sample_strobe;
  logic [31:0] sample_time;
  crp_pkg::crp_frame_t frame;
  logic frame_valid;
  logic pkt_busy;
  logic pkt_cancel;
  logic pkt_skip;
  logic [31:0] eff_period;
  logic [7:0] bus_load_pct;
  int delay;
  int lose_n;
  logic stall;
  int err_count;
  int checks;

  crp_result_publisher #(.CANCEL_CYC(CANCEL)) u_dut (.clk(clk), .rst_n(rst_n),
    .fd_mode(fd_mode), .period_cyc(period_cyc), .bit_time_cyc(bit_time_cyc),
    .msg_cfg(msg_cfg), .res_cfg(res_cfg), .calc_done(calc_done),
    .calc_results(calc_results), .tx_done(tx_done), .tx_lost(tx_lost),
    .sample_strobe(sample_strobe), .sample_time(sample_time), .frame(frame),
    .frame_valid(frame_valid), .pkt_busy(pkt_busy), .pkt_cancel(pkt_cancel),
    .pkt_skip(pkt_skip), .eff_period(eff_period), .bus_load_pct(bus_load_pct));

  crp_ctrl_model u_ctrl (.clk(clk), .rst_n(rst_n), .frame(frame), .frame_valid(frame_valid),
    .delay(delay), .lose_n(lose_n), .stall(stall), .tx_done(tx_done), .tx_lost(tx_lost));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [FW-1:0] exp, input logic [FW-1:0] got);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s exp %0h got %0h", what, exp, got);
    end
  endtask

  function automatic logic [31:0] rv(input int r);
    return {8'(8'h40 + r), 8'hA5, 8'h5A, 8'(r)};
  endfunction

  // result placed most significant byte first at byte offset o
  function automatic logic [511:0] put(input logic [511:0] d, input int o, input logic [31:0] v);
    for (int i = 0; i < 4; i++)
      d[8*(o+i) +: 8] = v[31-8*i -: 8];
    return d;
  endfunction

  function automatic crp_pkg::crp_frame_t mkf(input logic [10:0] id, input logic fd,
    input logic [3:0] dlc, input logic [511:0] d);
    crp_pkg::crp_frame_t f;
    f.id = id;
    f.ide = 1'b0;
    f.fd = fd;
    f.dlc = dlc;
    f.data = d;
    return f;
  endfunction

  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic clear();
    msg_cfg = '0;
    res_cfg = '0;
    u_ctrl.got.delete();
    for (int r = 0; r < crp_pkg::N_RES; r++)
      calc_results[r] = rv(r);
  endtask

  task automatic snap();
    calc_done = 1'b1;
    step();
    calc_done = 1'b0;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    repeat (3) step();
    while ((pkt_busy !== 1'b0 || frame_valid !== 1'b0) && n < 2000)
    begin
      step();
      n++;
    end
    chk("idle", 1'b1, n < 2000);
  endtask

  task automatic next_strobe(output int n);
    n = 0;
    do
    begin
      step();
      n++;
    end while (sample_strobe !== 1'b1 && n < 3 * P);
  endtask

  task automatic t_load();
    int n;
    logic [31:0] t0;
    clear();
    msg_cfg[0] = '{1'b1, 11'h123, 7'h08};
    repeat (4) step();
    chk("eff_period", P, eff_period);
    chk("bus_load", (crp_pkg::OVH_CLASSIC_BITS + 64) * 10 * 100 / P, bus_load_pct);
    next_strobe(n);
    t0 = sample_time;
    next_strobe(n);
    chk("period", P, n);
    chk("stamp", t0 + P, sample_time);
    $display("test load_period done");
  endtask

  task automatic t_pack();
    int n;
    crp_pkg::crp_frame_t e;
    clear();
    msg_cfg[0] = '{1'b1, 11'h123, 7'h08};
    msg_cfg[2] = '{1'b1, 11'h0A5, 7'h08};
    res_cfg[0] = '{1'b1, 3'h0, 6'h00};
    res_cfg[1] = '{1'b1, 3'h0, 6'h04};
    res_cfg[2] = '{1'b1, 3'h2, 6'h02};
    res_cfg[3] = '{1'b1, 3'h2, 6'h06};
    snap();
    n = 0;
    while (frame_valid !== 1'b1 && n < 20)
    begin
      step();
      n++;
    end
    chk("start", 1'b1, n <= 9);
    chk("busy", 1'b1, pkt_busy);
    wait_idle();
    chk("frames", 2, u_ctrl.got.size());
    e = mkf(11'h123, 1'b0, 4'h8, put(put('0, 0, rv(0)), 4, rv(1)));
    chk("msg0", e, u_ctrl.got[0]);
    chk("msg2", mkf(11'h0A5, 1'b0, 4'h8, put('0, 2, rv(2))), u_ctrl.got[1]);
    $display("test pack done");
  endtask

  task automatic t_fd();
    logic [511:0] d;
    clear();
    fd_mode = 1'b1;
    d = '0;
    msg_cfg[0] = '{1'b1, 11'h7FF, 7'h40};
    msg_cfg[3] = '{1'b1, 11'h001, 7'h14};
    for (int r = 0; r < crp_pkg::N_RES; r++)
    begin
      res_cfg[r] = '{1'b1, 3'h0, 6'(4 * r)};
      d = put(d, 4 * r, rv(r));
    end
    snap();
    wait_idle();
    chk("fd frames", 2, u_ctrl.got.size());
    chk("fd msg0", mkf(11'h7FF, 1'b1, 4'hF, d), u_ctrl.got[0]);
    chk("fd msg3", mkf(11'h001, 1'b1, 4'hB, '0), u_ctrl.got[1]);
    fd_mode = 1'b0;
    $display("test fd done");
  endtask

  task automatic t_lost();
    int nl;
    clear();
    msg_cfg[0] = '{1'b1, 11'h155, 7'h04};
    res_cfg[5] = '{1'b1, 3'h0, 6'h00};
    lose_n = 2;
    nl = u_ctrl.n_lost;
    snap();
    wait_idle();
    chk("lost", 2, u_ctrl.n_lost - nl);
    chk("retried", 1, u_ctrl.got.size());
    chk("msg0", mkf(11'h155, 1'b0, 4'h4, put('0, 0, rv(5))), u_ctrl.got[0]);
    lose_n = 0;
    $display("test lost done");
  endtask

  task automatic t_cancel();
    int n;
    clear();
    msg_cfg[0] = '{1'b1, 11'h200, 7'h08};
    res_cfg[0] = '{1'b1, 3'h0, 6'h00};
    stall = 1'b1;
    snap();
    repeat (5) step();
    snap();
    chk("skip", 1'b1, pkt_skip);
    n = 7;
    while (pkt_cancel !== 1'b1 && n < CANCEL + 50)
    begin
      step();
      n++;
    end
    chk("cancel time", 1'b1, n >= CANCEL && n <= CANCEL + 12);
    chk("offer dropped", 1'b0, frame_valid);
    stall = 1'b0;
    repeat (4) step();
    chk("stretched", P + 2 * ((P >> 3) + 1), eff_period);
    $display("test cancel done");
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_sim();
  end

  initial
  begin
    err_count = 0;
    checks = 0;
    rst_n = 1'b0;
    fd_mode = 1'b0;
    period_cyc = P;
    bit_time_cyc = 16'h000A;
    calc_done = 1'b0;
    delay = 5;
    lose_n = 0;
    stall = 1'b0;
    clear();
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    t_load();
    t_pack();
    t_fd();
    t_lost();
    t_cancel();
    end_sim();
  end
endmodule
